// ### inc/bmss_pkg.sv
// constants of the broker mapping, script and status register bank
`default_nettype none
package bmss_pkg;
  localparam logic [15:0] ADDR_PORT_SEL = 16'h0033;
  localparam logic [15:0] ADDR_SCRIPT_STATE = 16'h0034;
  localparam logic [15:0] ADDR_RUN_COUNT = 16'h0035;
  localparam logic [15:0] ADDR_CHAIN_FAULT = 16'h0036;
  localparam logic [15:0] ADDR_CHAIN_MAP = 16'h0e01;
  localparam logic [15:0] ADDR_SERIAL_MAP = 16'h0e21;
  localparam logic [15:0] ADDR_FBUS_MAP = 16'h0e41;
  localparam logic [15:0] ADDR_BIT_MAP = 16'h0f01;
  localparam int OUT_MAP_WORDS = 16;
  localparam int BIT_MAP_WORDS = 64;
  localparam int MAP_WORDS = 3 * OUT_MAP_WORDS + BIT_MAP_WORDS;
  localparam logic [6:0] IDX_CHAIN_MAP = 7'h00;
  localparam logic [6:0] IDX_SERIAL_MAP = 7'h10;
  localparam logic [6:0] IDX_FBUS_MAP = 7'h20;
  localparam logic [6:0] IDX_BIT_MAP = 7'h30;
  localparam logic [15:0] MAP_ADDR_LOW = 16'h1001;
  localparam logic [15:0] MAP_ADDR_HIGH = 16'h2fff;
  localparam logic [7:0] PORT_SEL_RESET = 8'h01;
  localparam logic [7:0] PORT_CFG_DEBUG = 8'h00;
  localparam logic [7:0] STATE_RESET = 8'h00;
  localparam logic [15:0] RUN_COUNT_RESET = 16'h0000;
  localparam logic [15:0] MAP_RESET = 16'h0000;
  localparam int COUNT_LSB = 0;
  localparam int COUNT_MSB = 14;
  localparam int SWAP_BIT = 15;
  localparam int SRC_BIT_LSB = 0;
  localparam int TGT_BIT_LSB = 4;
  typedef enum logic [7:0] {
    SCRIPT_INIT = 8'h00,
    SCRIPT_CYCLIC = 8'h01,
    SCRIPT_WAITING = 8'h02,
    SCRIPT_STOPPED = 8'h03,
    SCRIPT_FAILED = 8'h04
  } bmss_script_state_t;
  typedef enum logic [7:0] {
    FAULT_NONE = 8'h00,
    FAULT_CENTER_TAP = 8'h01,
    FAULT_DATA_IN = 8'h02,
    FAULT_IN_COUNT = 8'h03,
    FAULT_OUT_COUNT = 8'h04,
    FAULT_GENERAL = 8'h05
  } bmss_chain_fault_t;
endpackage
`default_nettype wire

// ### src/bmss_regs.sv
// broker mapping, script and shift chain status register bank
`timescale 1ns/1ns
`default_nettype none
module bmss_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register access from the protocol engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_err,
  // script engine
  input wire logic script_enable,
  input wire logic script_state_wr,
  input wire logic [7:0] script_state_in,
  input wire logic script_run_done,
  output logic script_active,
  output logic script_on_cfg_port,
  output logic script_on_serial_port,
  output logic cfg_menu_avail,
  // shift chain monitor
  input wire logic chain_check,
  input wire logic chain_center_silent,
  input wire logic chain_data_silent,
  input wire logic chain_in_count_bad,
  input wire logic chain_out_count_bad,
  input wire logic chain_general_fault,
  // data broker table lookup
  input wire logic brk_rd,
  input wire logic [6:0] brk_index,
  output logic [15:0] brk_word,
  output logic [14:0] brk_count,
  output logic brk_swap,
  output logic [3:0] brk_src_bit,
  output logic [3:0] brk_tgt_bit,
  output logic brk_valid,
  output logic map_error
);

  ////////////////////////////////////////////////////////////////////////
  // storage and address decode

  logic [7:0] port_sel_reg;
  logic [7:0] script_state_reg;
  logic [15:0] run_count_reg;
  logic [7:0] chain_fault_reg;
  logic [15:0] map_reg [bmss_pkg::MAP_WORDS];
  logic started_reg;
  logic map_error_next;
  logic map_hit;
  logic [6:0] map_idx;
  logic [15:0] off_chain;
  logic [15:0] off_serial;
  logic [15:0] off_fbus;
  logic [15:0] off_bit;

  always_comb begin
    off_chain = reg_addr - bmss_pkg::ADDR_CHAIN_MAP;
    off_serial = reg_addr - bmss_pkg::ADDR_SERIAL_MAP;
    off_fbus = reg_addr - bmss_pkg::ADDR_FBUS_MAP;
    off_bit = reg_addr - bmss_pkg::ADDR_BIT_MAP;
    map_hit = 1'b1;
    map_idx = 7'h00;
    if (off_chain < 16'(bmss_pkg::OUT_MAP_WORDS)) begin
      map_idx = bmss_pkg::IDX_CHAIN_MAP + off_chain[6:0];
    end else if (off_serial < 16'(bmss_pkg::OUT_MAP_WORDS)) begin
      map_idx = bmss_pkg::IDX_SERIAL_MAP + off_serial[6:0];
    end else if (off_fbus < 16'(bmss_pkg::OUT_MAP_WORDS)) begin
      map_idx = bmss_pkg::IDX_FBUS_MAP + off_fbus[6:0];
    end else if (off_bit < 16'(bmss_pkg::BIT_MAP_WORDS)) begin
      map_idx = bmss_pkg::IDX_BIT_MAP + off_bit[6:0];
    end else begin
      map_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // script port selection and activation

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_sel_reg <= bmss_pkg::PORT_SEL_RESET;
    end else if (reg_wr && reg_addr == bmss_pkg::ADDR_PORT_SEL) begin
      port_sel_reg <= reg_wdata[7:0];
    end
  end

  // enable is caught at the first edge after restart; a script that owns
  // the config port cannot be switched off until the next restart
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      started_reg <= 1'b0;
      script_active <= 1'b0;
    end else begin
      started_reg <= 1'b1;
      if (!started_reg) begin
        script_active <= script_enable;
      end else if (script_active && port_sel_reg == bmss_pkg::PORT_CFG_DEBUG) begin
        script_active <= 1'b1;
      end else begin
        script_active <= script_enable;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      script_on_cfg_port <= 1'b0;
      script_on_serial_port <= 1'b0;
      cfg_menu_avail <= 1'b1;
    end else begin
      script_on_cfg_port <= script_active && port_sel_reg == bmss_pkg::PORT_CFG_DEBUG;
      script_on_serial_port <= script_active && port_sel_reg != bmss_pkg::PORT_CFG_DEBUG;
      cfg_menu_avail <= !(script_active && port_sel_reg == bmss_pkg::PORT_CFG_DEBUG);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // script state and run counter, written only by the script engine

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      script_state_reg <= bmss_pkg::STATE_RESET;
    end else if (script_state_wr) begin
      if (script_state_in > 8'(bmss_pkg::SCRIPT_FAILED)) begin
        script_state_reg <= 8'(bmss_pkg::SCRIPT_FAILED);
      end else begin
        script_state_reg <= script_state_in;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_count_reg <= bmss_pkg::RUN_COUNT_RESET;
    end else if (script_run_done) begin
      run_count_reg <= run_count_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift chain fault code, most basic fault wins

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chain_fault_reg <= 8'(bmss_pkg::FAULT_NONE);
    end else if (chain_check) begin
      if (chain_center_silent) begin
        chain_fault_reg <= 8'(bmss_pkg::FAULT_CENTER_TAP);
      end else if (chain_data_silent) begin
        chain_fault_reg <= 8'(bmss_pkg::FAULT_DATA_IN);
      end else if (chain_in_count_bad) begin
        chain_fault_reg <= 8'(bmss_pkg::FAULT_IN_COUNT);
      end else if (chain_out_count_bad) begin
        chain_fault_reg <= 8'(bmss_pkg::FAULT_OUT_COUNT);
      end else if (chain_general_fault) begin
        chain_fault_reg <= 8'(bmss_pkg::FAULT_GENERAL);
      end else begin
        chain_fault_reg <= 8'(bmss_pkg::FAULT_NONE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mapping tables

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < bmss_pkg::MAP_WORDS; i++) begin
        map_reg[i] <= bmss_pkg::MAP_RESET;
      end
    end else if (reg_wr && map_hit) begin
      map_reg[map_idx] <= reg_wdata;
    end
  end

  // an entry with a nonzero count must point inside the process data areas
  function automatic logic out_of_range(input logic [15:0] a);
    out_of_range = a < bmss_pkg::MAP_ADDR_LOW || a > bmss_pkg::MAP_ADDR_HIGH;
  endfunction

  always_comb begin
    map_error_next = 1'b0;
    for (int e = 0; e < 3 * bmss_pkg::OUT_MAP_WORDS; e += 2) begin
      if (map_reg[e + 1][bmss_pkg::COUNT_MSB:bmss_pkg::COUNT_LSB] != 15'h0000 &&
          out_of_range(map_reg[e])) begin
        map_error_next = 1'b1;
      end
    end
    for (int b = 3 * bmss_pkg::OUT_MAP_WORDS; b < bmss_pkg::MAP_WORDS; b += 4) begin
      if (map_reg[b + 3][bmss_pkg::COUNT_MSB:bmss_pkg::COUNT_LSB] != 15'h0000 &&
          (out_of_range(map_reg[b]) || out_of_range(map_reg[b + 1]))) begin
        map_error_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      map_error <= 1'b0;
    end else begin
      map_error <= map_error_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // broker lookup: raw word plus its count, swap and bit fields

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      brk_word <= 16'h0000;
      brk_count <= 15'h0000;
      brk_swap <= 1'b0;
      brk_src_bit <= 4'h0;
      brk_tgt_bit <= 4'h0;
      brk_valid <= 1'b0;
    end else begin
      brk_valid <= brk_rd;
      if (brk_rd) begin
        brk_word <= map_reg[brk_index];
        brk_count <= map_reg[brk_index][bmss_pkg::COUNT_MSB:bmss_pkg::COUNT_LSB];
        brk_swap <= map_reg[brk_index][bmss_pkg::SWAP_BIT];
        brk_src_bit <= map_reg[brk_index][bmss_pkg::SRC_BIT_LSB +: 4];
        brk_tgt_bit <= map_reg[brk_index][bmss_pkg::TGT_BIT_LSB +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads; writes to read-only words change nothing

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      reg_err <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_err <= 1'b0;
      if (reg_rd) begin
        if (reg_addr == bmss_pkg::ADDR_PORT_SEL) begin
          reg_rdata <= {8'h00, port_sel_reg};
        end else if (reg_addr == bmss_pkg::ADDR_SCRIPT_STATE) begin
          reg_rdata <= {8'h00, script_state_reg};
        end else if (reg_addr == bmss_pkg::ADDR_RUN_COUNT) begin
          reg_rdata <= run_count_reg;
        end else if (reg_addr == bmss_pkg::ADDR_CHAIN_FAULT) begin
          reg_rdata <= {8'h00, chain_fault_reg};
        end else if (map_hit) begin
          reg_rdata <= map_reg[map_idx];
        end else begin
          reg_rdata <= 16'h0000;
          reg_err <= 1'b1;
        end
      end else if (reg_wr) begin
        reg_err <= !(map_hit || reg_addr == bmss_pkg::ADDR_PORT_SEL ||
                     reg_addr == bmss_pkg::ADDR_SCRIPT_STATE ||
                     reg_addr == bmss_pkg::ADDR_RUN_COUNT ||
                     reg_addr == bmss_pkg::ADDR_CHAIN_FAULT);
      end
    end
  end

endmodule // bmss_regs
`default_nettype wire

// ### tb/bmss_regs_chk.sv
// port assertions for the mapping and status register bank
`timescale 1ns/1ns
`default_nettype none
module bmss_regs_chk (
  // clock, reset, register access
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rvalid,
  input wire logic reg_err,
  // script
  input wire logic script_enable,
  input wire logic script_active,
  input wire logic script_on_cfg_port,
  input wire logic cfg_menu_avail,
  // broker lookup
  input wire logic [15:0] brk_word,
  input wire logic [14:0] brk_count,
  input wire logic brk_swap,
  input wire logic [3:0] brk_src_bit,
  input wire logic [3:0] brk_tgt_bit,
  input wire logic brk_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence count_rd_s;
    reg_rd && reg_addr == bmss_pkg::ADDR_RUN_COUNT;
  endsequence
  chk_count_read_ack: assert property (count_rd_s |=> reg_rvalid && !reg_err)
    else $error("run counter read not answered");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  chk_ro_write_quiet: assert property (reg_wr && reg_addr inside {16'h0034, 16'h0035, 16'h0036}
    |=> !reg_err)
    else $error("write to read-only register flagged");
  chk_enable_follow: assert property (script_enable |=> script_active)
    else $error("script not active after enable");
  chk_cfg_sticky: assert property (script_on_cfg_port && !script_enable |=> script_active)
    else $error("config port script stopped before restart");
  chk_menu_blocked: assert property (script_on_cfg_port |-> !cfg_menu_avail)
    else $error("config menu usable while script holds port");
  chk_bit_fields: assert property (brk_valid |-> brk_src_bit == brk_word[3:0]
    && brk_tgt_bit == brk_word[7:4])
    else $error("bit position fields wrong");
  chk_count_swap: assert property (brk_valid |-> brk_count == brk_word[14:0]
    && brk_swap == brk_word[15])
    else $error("count or swap field wrong");
endmodule // bmss_regs_chk
bind bmss_regs bmss_regs_chk u_chk (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_rvalid,
  .reg_err, .script_enable, .script_active, .script_on_cfg_port, .cfg_menu_avail, .brk_word,
  .brk_count, .brk_swap, .brk_src_bit, .brk_tgt_bit, .brk_valid);
`default_nettype wire

// ### tb/test_bmss_regs.sv
// self-checking bench for the mapping and status register bank
`timescale 1ns/1ns
`default_nettype none
module test_bmss_regs;
  logic mclk, rst, reg_wr, reg_rd, reg_rvalid, reg_err, script_enable, script_state_wr;
  logic script_run_done, script_active, script_on_cfg_port, script_on_serial_port;
  logic cfg_menu_avail, chain_check, brk_rd, brk_swap, brk_valid, map_error;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, brk_word, a;
  logic [7:0] script_state_in;
  logic [4:0] flags;
  logic [6:0] brk_index;
  logic [14:0] brk_count;
  logic [3:0] brk_src_bit, brk_tgt_bit;
  logic [15:0] tbl [4] = '{16'h0e01, 16'h0e21, 16'h0e41, 16'h0f01};
  logic [15:0] srcs [4] = '{16'h1000, 16'h1001, 16'h2fff, 16'h3000};
  int miscompares, samples_checked;
  bmss_regs dut (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .reg_err, .script_enable, .script_state_wr, .script_state_in, .script_run_done,
    .script_active, .script_on_cfg_port, .script_on_serial_port, .cfg_menu_avail, .chain_check,
    .chain_center_silent(flags[0]), .chain_data_silent(flags[1]), .chain_in_count_bad(flags[2]),
    .chain_out_count_bad(flags[3]), .chain_general_fault(flags[4]), .brk_rd, .brk_index,
    .brk_word, .brk_count, .brk_swap, .brk_src_bit, .brk_tgt_bit, .brk_valid, .map_error);
  always #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] ad, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] ad, input logic [15:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rvalid), 16'h0001);
    chk(reg_rdata, exp);
  endtask
  task automatic brk(input logic [6:0] idx);
    @(posedge mclk);
    brk_rd <= 1'b1;
    brk_index <= idx;
    @(posedge mclk);
    brk_rd <= 1'b0;
    #1;
    chk(16'(brk_valid), 16'h0001);
  endtask
  task automatic mapchk(input logic [15:0] e);
    @(posedge mclk);
    #1;
    chk(16'(map_error), e);
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic end_of_test;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #150000;
    miscompares++;
    end_of_test;
  end
  initial begin
    {mclk, reg_wr, reg_rd, script_enable, script_state_wr, script_run_done, chain_check} = '0;
    {brk_rd, reg_addr, reg_wdata, script_state_in, flags, brk_index} = '0;
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(16'h0033, 16'h0001);
    rd(16'h0035, 16'h0000);
    rd(16'h0037, 16'h0000);
    chk(16'(reg_err), 16'h0001);
    wr(16'h0037, 16'h0001);
    #1;
    chk(16'(reg_err), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      a = tbl[i] + ((i == 3) ? 16'h003f : 16'h000f);
      rd(tbl[i], 16'h0000);
      wr(a, 16'h1a5c);
      rd(a, 16'h1a5c);
      wr(a, 16'h0000);
    end
    for (int s = 0; s < 6; s++) begin
      @(posedge mclk);
      script_state_wr <= 1'b1;
      script_state_in <= 8'(s);
      @(posedge mclk);
      script_state_wr <= 1'b0;
      rd(16'h0034, (s > 4) ? 16'h0004 : 16'(s));
    end
    wr(16'h0034, 16'h0001);
    #1;
    chk(16'(reg_err), 16'h0000);
    rd(16'h0034, 16'h0004);
    @(posedge mclk);
    script_run_done <= 1'b1;
    repeat (3) @(posedge mclk);
    script_run_done <= 1'b0;
    wr(16'h0035, 16'h00ff);
    rd(16'h0035, 16'h0003);
    for (int k = 0; k < 7; k++) begin
      @(posedge mclk);
      flags <= (k < 5) ? 5'(1 << k) : ((k == 5) ? 5'h1c : 5'h00);
      chain_check <= 1'b1;
      @(posedge mclk);
      chain_check <= 1'b0;
      rd(16'h0036, (k < 5) ? 16'(k + 1) : ((k == 5) ? 16'h0003 : 16'h0000));
    end
    wr(16'h0f03, 16'h00a5);
    wr(16'h0f04, 16'h8003);
    mapchk(16'h0001);
    brk(7'h32);
    chk(16'(brk_src_bit), 16'h0005);
    chk(16'(brk_tgt_bit), 16'h000a);
    chk(brk_word, 16'h00a5);
    brk(7'h33);
    chk(16'(brk_count), 16'h0003);
    chk(16'(brk_swap), 16'h0001);
    wr(16'h0f01, 16'h1001);
    wr(16'h0f02, 16'h2fff);
    mapchk(16'h0000);
    wr(16'h0f04, 16'h0000);
    wr(16'h0e02, 16'h0002);
    for (int m = 0; m < 4; m++) begin
      wr(16'h0e01, srcs[m]);
      mapchk(16'((m == 0) || (m == 3)));
    end
    wr(16'h0033, 16'h0000);
    rd(16'h0033, 16'h0000);
    @(posedge mclk);
    script_enable <= 1'b1;
    settle;
    chk(16'(cfg_menu_avail), 16'h0000);
    @(posedge mclk);
    script_enable <= 1'b0;
    settle;
    chk(16'(script_on_cfg_port), 16'h0001);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    settle;
    chk(16'(script_active), 16'h0000);
    chk(16'(cfg_menu_avail), 16'h0001);
    chk(16'(map_error), 16'h0000);
    rd(16'h0035, 16'h0000);
    rd(16'h0e01, 16'h0000);
    rd(16'h0033, 16'h0001);
    @(posedge mclk);
    script_enable <= 1'b1;
    settle;
    chk(16'(script_on_serial_port), 16'h0001);
    chk(16'(script_on_cfg_port), 16'h0000);
    @(posedge mclk);
    script_enable <= 1'b0;
    settle;
    chk(16'(script_active), 16'h0000);
    end_of_test;
  end
endmodule // test_bmss_regs
`default_nettype wire
